/* rtl/ebt_consts.svh */
`ifndef EBT_CONSTS_SVH
`define EBT_CONSTS_SVH
// register byte offsets
`define EBT_OFS_COUNT 5'h00
`define EBT_OFS_OPTION 5'h04
`define EBT_OFS_INTCTL 5'h08
`define EBT_OFS_IRQ_STATUS 5'h0c
`define EBT_OFS_IRQ_MASK 5'h10
// option_control fields
`define EBT_OPT_RESET 8'hff
`define EBT_OPT_CSS 5
`define EBT_OPT_CES 4
`define EBT_OPT_PSA 3
// interrupt_control fields
`define EBT_ICR_RESET 8'h00
`define EBT_ICR_OIE 5
`define EBT_ICR_OVF 2
// interrupt status bits
`define EBT_IRQ_OVF 0
`define EBT_IRQ_WDT 1
// instruction cycle holdoff after a count write
`define EBT_WR_HOLD 2'd2
`endif

/* rtl/ebt_pkg.sv */
package ebt_pkg;
    typedef struct packed {
        logic [1:0] rsvd;
        logic css;
        logic ces;
        logic prescaler_assign_select;
        logic [2:0] ratio;
    } ebt_opt_t;
    typedef enum logic [2:0] {
        EBT_IDLE = 3'b001,
        EBT_RESP = 3'b010,
        EBT_DONE = 3'b100
    } ebt_bus_st_t;
endpackage

/* rtl/ebt_sync.sv */
`timescale 1ns/1ps
module ebt_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic meta_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

/* rtl/ebt_prescaler.sv */
`timescale 1ns/1ps
`include "ebt_consts.svh"
module ebt_prescaler (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic tick_in,
    input wire logic [2:0] ratio,
    output logic tick_out
);
    // divide by 2^(ratio+1), counter never visible to software
    logic [7:0] cnt_q;
    logic [7:0] nxt;
    assign nxt = cnt_q + 8'h01;
    assign tick_out = tick_in && (cnt_q[ratio] == 1'b1) && (nxt[ratio] == 1'b0);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
        end else if (clr) begin
            cnt_q <= 8'h00;
        end else if (tick_in) begin
            cnt_q <= nxt;
        end
    end
endmodule

/* rtl/ebt_timer.sv */
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ebt_consts.svh"
// Summary of operation
// - 8-bit count register, readable and writable, acts as timer or counter.
// - source select 0 counts instruction cycles, or prescaler pulses.
// - after a count write, increments are held off two instruction cycles.
// - source select 1 counts edges of the external count input.
// - edge select bit picks rising or falling counting edges.
// - one 8-bit prescaler serves timer or watchdog, never both.
// - assign bit 0 routes prescaler to timer, 1 to watchdog.
// - timer prescale offers eight ratios, 1:2 through 1:256.
// - undivided 1:1 timer rate only when prescaler belongs to watchdog.
// - prescaler count cannot be read or written by software.
// - count write clears prescaler while it belongs to the timer.
// - watchdog clear resets watchdog and prescaler when assigned there.
// - wrap from ff to 00 always sets the overflow flag.
// - edge select 1 counts high-to-low, 0 counts low-to-high.
// - timer frozen during sleep.
module ebt_timer
    import ebt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic instr_cycle,
    input wire logic sleep,
    input wire logic wdt_clear,
    input wire logic ext_count_in,
    output logic wdt_tick_q,
    output logic overflow_irq_q,
    output logic irq_q
);
    // ==========================================
    // bus slave
    ebt_bus_st_t st_q;
    logic [31:0] rdata_q;
    logic wait_q;
    logic acc;
    logic wr_now;
    logic rd_now;
    logic [4:0] addr;
    logic be0;
    logic [7:0] wd;
    logic [7:0] count_q;
    ebt_opt_t opt_q;
    logic [7:0] icr_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    assign addr = avs_address;
    assign be0 = avs_byteenable[0];
    assign wd = avs_writedata[7:0];
    assign acc = avs_read || avs_write;
    assign wr_now = avs_write && (st_q == EBT_RESP);
    assign rd_now = avs_read && (st_q == EBT_RESP);
    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;
    // waitrequest idles high and drops for the answer cycle only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= EBT_IDLE;
            wait_q <= 1'b1;
        end else begin
            case (st_q)
                EBT_IDLE: begin
                    if (acc) begin
                        st_q <= EBT_RESP;
                        wait_q <= 1'b0;
                    end
                end
                EBT_RESP: begin
                    st_q <= EBT_DONE;
                    wait_q <= 1'b1;
                end
                default: begin
                    st_q <= EBT_IDLE;
                    wait_q <= 1'b1;
                end
            endcase
        end
    end
    logic wr_count;
    logic wr_opt;
    logic wr_icr;
    logic wr_mask;
    logic rd_stat;
    assign wr_count = wr_now && be0 && (addr == `EBT_OFS_COUNT);
    assign wr_opt = wr_now && be0 && (addr == `EBT_OFS_OPTION);
    assign wr_icr = wr_now && be0 && (addr == `EBT_OFS_INTCTL);
    assign wr_mask = wr_now && be0 && (addr == `EBT_OFS_IRQ_MASK);
    assign rd_stat = rd_now && (addr == `EBT_OFS_IRQ_STATUS);
    // read data registered on the request's first cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else if (st_q == EBT_IDLE && avs_read) begin
            if (addr == `EBT_OFS_COUNT) begin
                rdata_q <= {24'h0, count_q};
            end else if (addr == `EBT_OFS_OPTION) begin
                rdata_q <= {24'h0, opt_q};
            end else if (addr == `EBT_OFS_INTCTL) begin
                rdata_q <= {24'h0, icr_q};
            end else if (addr == `EBT_OFS_IRQ_STATUS) begin
                rdata_q <= {30'h0, irq_stat_q};
            end else if (addr == `EBT_OFS_IRQ_MASK) begin
                rdata_q <= {30'h0, irq_mask_q};
            end else begin
                rdata_q <= 32'h0;
            end
        end
    end
    // ==========================================
    // option register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            opt_q <= `EBT_OPT_RESET;
        end else if (wr_opt) begin
            opt_q <= wd;
        end
    end
    // ==========================================
    // external input path
    logic ext_s;
    logic ext_prev_q;
    logic ext_edge;
    ebt_sync u_sync (
        .clk(clk),
        .rst(rst),
        .din(ext_count_in),
        .dout(ext_s)
    );
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_s;
        end
    end
    // edge select 1 = falling, 0 = rising
    assign ext_edge = opt_q.ces ? (ext_prev_q && !ext_s) : (!ext_prev_q && ext_s);
    // ==========================================
    // shared prescaler
    logic src_tick;
    logic ps_in;
    logic ps_out;
    logic ps_clr;
    logic tmr_tick;
    assign src_tick = opt_q.css ? ext_edge : instr_cycle;
    assign ps_in = opt_q.prescaler_assign_select ? instr_cycle : src_tick;
    // clear source follows the owner, so the other side cannot reset it
    assign ps_clr = opt_q.prescaler_assign_select ? wdt_clear : wr_count;
    ebt_prescaler u_ps (
        .clk(clk),
        .rst(rst),
        .clr(ps_clr),
        .tick_in(ps_in),
        .ratio(opt_q.ratio),
        .tick_out(ps_out)
    );
    // ratio to prescaler; bypass when watchdog owns it
    assign tmr_tick = opt_q.prescaler_assign_select ? src_tick : ps_out;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_tick_q <= 1'b0;
        end else begin
            wdt_tick_q <= opt_q.prescaler_assign_select && ps_out;
        end
    end
    // ==========================================
    // count register
    logic [1:0] hold_q;
    logic inc;
    logic wrap;
    // holdoff counts instruction cycles, not clocks
    assign inc = tmr_tick && (hold_q == 2'd0) && !sleep;
    assign wrap = inc && (count_q == 8'hff);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_q <= 2'd0;
        end else if (wr_count) begin
            hold_q <= `EBT_WR_HOLD;
        end else if (instr_cycle && hold_q != 2'd0) begin
            hold_q <= hold_q - 2'd1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= 8'h00;
        end else if (wr_count) begin
            count_q <= wd;
        end else if (inc) begin
            count_q <= count_q + 8'h01;
        end
    end
    // ==========================================
    // interrupt control, set wins over software clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            icr_q <= `EBT_ICR_RESET;
        end else begin
            if (wr_icr) begin
                icr_q <= wd;
            end
            if (wrap) begin
                icr_q[`EBT_ICR_OVF] <= 1'b1;
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overflow_irq_q <= 1'b0;
        end else begin
            overflow_irq_q <= icr_q[`EBT_ICR_OVF] && icr_q[`EBT_ICR_OIE];
        end
    end
    // ==========================================
    // block interrupt status and mask
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= 2'b00;
        end else begin
            // drop only the bits the read returned; an event in the capture cycle survives
            irq_stat_q <= (rd_stat ? (irq_stat_q & ~rdata_q[1:0]) : irq_stat_q) | {opt_q.prescaler_assign_select && ps_out, wrap};
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_mask_q <= 2'b00;
        end else if (wr_mask) begin
            irq_mask_q <= wd[1:0];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end
    // ==========================================
    // assertions
    property p_wrap_flag;
        @(posedge clk) disable iff (rst) wrap |=> icr_q[`EBT_ICR_OVF];
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("overflow flag not set on wrap");
    property p_hold;
        @(posedge clk) disable iff (rst) wr_count |=> (count_q == $past(wd)) && hold_q == 2'd2;
    endproperty
    a_hold: assert property (p_hold) else $error("count write not loaded or holdoff wrong");
    property p_no_inc_hold;
        @(posedge clk) disable iff (rst) (hold_q != 2'd0 && !wr_count) |=> count_q == $past(count_q);
    endproperty
    a_no_inc_hold: assert property (p_no_inc_hold) else $error("count advanced during holdoff");
    property p_sleep;
        @(posedge clk) disable iff (rst) (sleep && !wr_count) |=> $stable(count_q);
    endproperty
    a_sleep: assert property (p_sleep) else $error("count advanced in sleep");
    property p_inc;
        @(posedge clk) disable iff (rst) inc && !wr_count |=> count_q == $past(count_q) + 8'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("count did not advance");
    property p_psa_bypass;
        @(posedge clk) disable iff (rst) opt_q.prescaler_assign_select && !opt_q.css |-> tmr_tick == instr_cycle;
    endproperty
    a_psa_bypass: assert property (p_psa_bypass) else $error("no 1:1 rate with watchdog prescale");
    property p_ps_excl;
        @(posedge clk) disable iff (rst) !opt_q.prescaler_assign_select |=> !wdt_tick_q;
    endproperty
    a_ps_excl: assert property (p_ps_excl) else $error("prescaler served both");
    property p_edge;
        @(posedge clk) disable iff (rst) ext_edge |-> (ext_s == !opt_q.ces);
    endproperty
    a_edge: assert property (p_edge) else $error("wrong counting edge");
    property p_irq;
        @(posedge clk) disable iff (rst) (icr_q[`EBT_ICR_OVF] && icr_q[`EBT_ICR_OIE]) |=> overflow_irq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("overflow request missing");
    property p_ps_clr_wr;
        @(posedge clk) disable iff (rst) (wr_count && !opt_q.prescaler_assign_select) |=> u_ps.cnt_q == 8'h00;
    endproperty
    a_ps_clr_wr: assert property (p_ps_clr_wr) else $error("count write left prescaler running");
    property p_ps_clr_wdt;
        @(posedge clk) disable iff (rst) (wdt_clear && opt_q.prescaler_assign_select) |=> u_ps.cnt_q == 8'h00;
    endproperty
    a_ps_clr_wdt: assert property (p_ps_clr_wdt) else $error("watchdog clear left prescaler running");
    property p_wait_one;
        @(posedge clk) disable iff (rst) !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("answer cycle longer than one clock");
    property p_stat_sticky;
        @(posedge clk) disable iff (rst) (irq_stat_q[`EBT_IRQ_OVF] && !rd_stat) |=> irq_stat_q[`EBT_IRQ_OVF];
    endproperty
    a_stat_sticky: assert property (p_stat_sticky) else $error("overflow status lost without read");
    property p_flag_sticky;
        @(posedge clk) disable iff (rst) (icr_q[`EBT_ICR_OVF] && !wr_icr) |=> icr_q[`EBT_ICR_OVF];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag cleared by hardware");
    property p_irq_level;
        @(posedge clk) disable iff (rst) (|(irq_stat_q & irq_mask_q)) |=> irq_q;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("unmasked status without interrupt");
    property p_wdt_tick;
        @(posedge clk) disable iff (rst) (opt_q.prescaler_assign_select && ps_out) |=> wdt_tick_q;
    endproperty
    a_wdt_tick: assert property (p_wdt_tick) else $error("watchdog tick missing");
    property p_ext_only;
        @(posedge clk) disable iff (rst) (opt_q.css && inc) |-> ext_edge;
    endproperty
    a_ext_only: assert property (p_ext_only) else $error("counter mode advanced without pin edge");
    property p_timer_src;
        @(posedge clk) disable iff (rst) (!opt_q.css && inc) |-> instr_cycle;
    endproperty
    a_timer_src: assert property (p_timer_src) else $error("timer mode advanced without cycle");
    property p_wrap_zero;
        @(posedge clk) disable iff (rst) (wrap && !wr_count) |=> count_q == 8'h00;
    endproperty
    a_wrap_zero: assert property (p_wrap_zero) else $error("count did not wrap to zero");
    property p_opt_write;
        @(posedge clk) disable iff (rst) wr_opt |=> opt_q == $past(wd);
    endproperty
    a_opt_write: assert property (p_opt_write) else $error("option write not taken");
    property p_rd_count;
        @(posedge clk) disable iff (rst) (st_q == EBT_IDLE && avs_read && addr == `EBT_OFS_COUNT)
            |=> avs_readdata == {24'h0, $past(count_q)};
    endproperty
    a_rd_count: assert property (p_rd_count) else $error("count read returned wrong value");
    // ==========================================
    // cover points
    c_wrap: cover property (@(posedge clk) disable iff (rst) wrap);
    c_ext: cover property (@(posedge clk) disable iff (rst) opt_q.css && inc);
    c_ps: cover property (@(posedge clk) disable iff (rst) !opt_q.prescaler_assign_select && ps_out);
    c_hold: cover property (@(posedge clk) disable iff (rst) hold_q != 2'd0 && tmr_tick);
    c_wdt: cover property (@(posedge clk) disable iff (rst) wdt_tick_q);
endmodule

/* tb/ebt_edge_src.sv */
`timescale 1ns/1ps
// =====================================
// external edge source on the count pin
module ebt_edge_src (
    input wire logic clk,
    output logic pin
);
    initial pin = 1'b0;
    // new level after an edge, held past the synchroniser latency
    task automatic drive(input logic v);
        pin <= v;
        repeat (6) @(posedge clk);
    endtask
endmodule

/* tb/eight_bit_timer_with_shared_prescaler_test.sv */
`timescale 1ns/1ps
`include "ebt_consts.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module eight_bit_timer_with_shared_prescaler_test
    import ebt_pkg::*;
;
    localparam logic [4:0] CNT = `EBT_OFS_COUNT;
    localparam logic [4:0] OPT = `EBT_OFS_OPTION;
    localparam logic [4:0] ICR = `EBT_OFS_INTCTL;
    localparam logic [4:0] STS = `EBT_OFS_IRQ_STATUS;
    localparam logic [4:0] MSK = `EBT_OFS_IRQ_MASK;
    localparam logic [4:0] UNM = 5'h14;
    logic clk, rst, avs_read, avs_write, instr_cycle, sleep, wdt_clear;
    logic avs_waitrequest, ext_count_in, wdt_tick_q, overflow_irq_q, irq_q;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable;
    logic [7:0] m_cnt;
    logic [31:0] seed = 32'hdbcc;
    int error_cnt = 0;
    int num_checks = 0;
    int wdt_seen = 0;
    int k;

    ebt_timer ebt_timer_inst (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .instr_cycle(instr_cycle),
        .sleep(sleep), .wdt_clear(wdt_clear), .ext_count_in(ext_count_in), .wdt_tick_q(wdt_tick_q),
        .overflow_irq_q(overflow_irq_q), .irq_q(irq_q));
    ebt_edge_src ebt_edge_src_inst (.clk(clk), .pin(ext_count_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wdt_tick_q === 1'b1) wdt_seen++;
    end
    // =====================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic ebt_opt_t mk_opt(input logic s, input logic e, input logic p, input logic [2:0] r);
        mk_opt = '{rsvd: 2'b11, css: s, ces: e, prescaler_assign_select: p, ratio: r};
    endfunction
    // hold request until waitrequest seen low, then one dead cycle
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, q);
    endtask
    task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] ex);
        bus(1'b0, a, 32'h0, q);
        `CHK(nm, ex, q)
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            instr_cycle <= 1'b1;
            @(posedge clk);
            instr_cycle <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    task automatic clr_wdt();
        wdt_clear <= 1'b1;
        @(posedge clk);
        wdt_clear <= 1'b0;
        @(posedge clk);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #500000;
        error_cnt++;
        conclude();
    end
    // =====================================
    // scenarios
    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        instr_cycle = 1'b0;
        sleep = 1'b0;
        wdt_clear = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk("option_reset", OPT, 32'hff);
        rd_chk("intctl_reset", ICR, 32'h0);
        wr(UNM, 8'h5a);
        rd_chk("unmapped", UNM, 32'h0);
        wdt_seen = 0;
        for (int n = 0; n < 8; n++) begin
            wr(OPT, mk_opt(1'b0, 1'b0, 1'b0, n[2:0]));
            bus(1'b0, CNT, 32'h0, q);
            m_cnt = q[7:0] + 8'h1;
            tick(2 << n);
            rd_chk("prescaled", CNT, {24'h0, m_cnt});
        end
        `CHK("no_wdt_tick", 0, wdt_seen)
        clr_wdt();
        wr(CNT, 8'h00);
        wr(OPT, mk_opt(1'b0, 1'b0, 1'b1, 3'd2));
        clr_wdt();
        wdt_seen = 0;
        tick(7);
        repeat (4) @(posedge clk);
        `CHK("wdt_early", 0, wdt_seen)
        tick(1);
        repeat (4) @(posedge clk);
        `CHK("wdt_tick", 1, wdt_seen)
        wr(ICR, 8'h20);
        wr(MSK, 8'h01);
        m_cnt = 8'hfc + 8'(rnd() & 32'h3);
        wr(CNT, m_cnt);
        tick(2);
        rd_chk("holdoff", CNT, {24'h0, m_cnt});
        tick(4);
        m_cnt = m_cnt + 8'h4;
        rd_chk("one_to_one", CNT, {24'h0, m_cnt});
        rd_chk("flag_set", ICR, 32'h24);
        `CHK("ovf_irq", 1'b1, overflow_irq_q)
        `CHK("irq_on", 1'b1, irq_q)
        bus(1'b0, STS, 32'h0, q);
        `CHK("sts_ovf", 1'b1, q[0])
        @(posedge clk);
        `CHK("irq_off", 1'b0, irq_q)
        bus(1'b0, STS, 32'h0, q);
        `CHK("sts_clr", 1'b0, q[0])
        wr(ICR, 8'h20);
        @(posedge clk);
        `CHK("ovf_clr", 1'b0, overflow_irq_q)
        rd_chk("flag_clr", ICR, 32'h20);
        sleep <= 1'b1;
        tick(3);
        rd_chk("frozen", CNT, {24'h0, m_cnt});
        avs_byteenable <= 4'he;
        wr(CNT, ~m_cnt);
        avs_byteenable <= 4'hf;
        rd_chk("lane_off", CNT, {24'h0, m_cnt});
        sleep <= 1'b0;
        for (int c = 0; c < 2; c++) begin
            wr(OPT, mk_opt(1'b1, c[0], 1'b1, 3'd0));
            bus(1'b0, CNT, 32'h0, q);
            m_cnt = q[7:0];
            k = 1 + int'(rnd() % 3);
            repeat (k) begin
                ebt_edge_src_inst.drive(1'b1);
                m_cnt = m_cnt + 8'(c == 0);
                rd_chk("rise", CNT, {24'h0, m_cnt});
                ebt_edge_src_inst.drive(1'b0);
                m_cnt = m_cnt + 8'(c == 1);
                rd_chk("fall", CNT, {24'h0, m_cnt});
            end
        end
        conclude();
    end
endmodule
